// *** ptb_bridge.sv ***
/*
 Window and mailbox bridge between a PCI target core and a user local bus.
 Assumes one-cycle window requests answered a cycle later by ack or retry,
 and a local bus clock, sampled as data, slower than half of clock.
*/
// Our own choices: the strobed register port and the register addresses.
// What this block does
// - Two four-byte mailboxes, one toward local side, one toward PCI side.
// - Each mailbox byte has a full flag, readable from both sides.
// - A control field picks the mailbox byte whose write raises an interrupt.
// - Mailbox interrupts go to the PCI side or the local side.
// - Local pins load the inbound mailbox with one strobe, interrupting PCI.
// - A local pin drives the PCI interrupt directly.
// - Four separately configured windows exist.
// - Each window has width 8/16/32, memory or I/O, size to 512 MB.
// - Pending requests show direction, byte lanes, window and burst on pins.
// - Unfinished direct transfers are answered with retry until complete.
// - Single and burst accesses both work, bursts at full rate via FIFOs.
// - Separate 32-byte FIFOs hold PCI read data and PCI write data.
// - With the write FIFO on, writes are taken with no wait while it has space; when it is full they get retry.
// - With the read FIFO on, data is prefetched and reads served from it.
// - Read FIFO and write FIFO are enabled independently.
// - In active mode the engine strobes the local bus by itself.
// - Active mode inserts zero to seven programmable wait states.
// - A released strobe is driven high one clock before floating.
// - Window settings reset to defaults and may be loaded at start-up.
`timescale 1ns/1ns
`include "ptb_consts.svh"
module ptb_bridge
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Window requests from the PCI target core
   input wire logic win_req,
   input wire logic win_req_write,
   input wire logic [1:0] win_req_window,
   input wire logic [3:0] win_req_be,
   input wire logic win_req_burst,
   input wire logic [28:0] win_req_addr,
   input wire logic [31:0] win_req_wdata,
   output logic win_ack,
   output logic win_retry,
   output logic [31:0] win_rdata,
   output logic pci_int_n,
   // Start-up loading of window settings
   input wire logic cfg_load,
   input wire logic [1:0] cfg_load_window,
   input wire logic [8:0] cfg_load_value,
   // Local bus strobes and data
   input wire logic local_clock,
   input wire logic local_rd_n_in,
   output logic local_rd_n_out,
   input wire logic local_wr_n_in,
   output logic local_wr_n_out,
   output logic local_strobe_oe,
   input wire logic [31:0] local_data_in,
   output logic [31:0] local_data_out,
   output logic local_data_oe,
   // Local request indication
   output logic lreq_valid,
   output logic lreq_write,
   output logic [3:0] lreq_be,
   output logic [1:0] lreq_window,
   output logic lreq_burst,
   output logic [28:0] lreq_addr,
   output logic [1:0] lreq_width,
   output logic lreq_io,
   // Local mailbox pins
   input wire logic mb_load,
   input wire logic [31:0] mb_load_data,
   input wire logic mb_rd,
   input wire logic [1:0] mb_rd_sel,
   output logic [7:0] mb_rd_data,
   output logic [7:0] mb_status,
   input wire logic local_irq_n,
   output logic local_int_n,
   output ptb_pkg::ptb_eng_t engine_state
);
   import ptb_pkg::*;

   logic [`PTB_SYNC_W-1:0] sync1, sync2, sync3;
   logic lclk_rise, rd_rise, wr_rise, rd_low, load_rise, mbrd_rise;
   logic [`PTB_CTRL_W-1:0] ctrl;
   logic [`PTB_WIN_W-1:0] win_cfg [`PTB_WINDOWS];
   logic [31:0] mb_out, mb_in;
   logic [3:0] out_full, in_full;
   logic [1:0] int_sel;
   logic [2:0] wait_cnt;
   logic wf_push, wf_full, wf_empty, rf_push, rf_pop, rf_full, rf_empty;
   logic [`PTB_WF_W-1:0] wf_dout, req_entry, dw_entry;
   logic [31:0] rf_dout, rd_hold, eng_rdata;
   logic [`PTB_FIFO_AW:0] wf_count, rf_count;
   ptb_tr_t dw_st, rd_st;
   logic [`PTB_WF_W-1:0] rd_entry;
   logic pf_active, pf_flush, eng_go, eng_done;
   logic [28:0] pf_addr;
   logic [3:0] pf_be;
   logic [1:0] pf_win;
   ptb_op_t pick, eng_op;
   logic [`PTB_WF_W-1:0] pick_entry;
   logic [`PTB_WIN_W-1:0] req_cfg;

   // Offset inside a window, limited to the window's size.
   function automatic logic [28:0] win_mask(input logic [4:0] size);
      win_mask = ~(`PTB_ADDR_ALL << size);
   endfunction

   // Two flops for every local pin; a third stage on the second only,
   // so edge detection never looks at a flop that may be metastable.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         sync1 <= `PTB_SYNC_RST;
         sync2 <= `PTB_SYNC_RST;
         sync3 <= `PTB_SYNC_RST;
      end
      else
      begin
         sync1 <= {local_data_in, mb_load_data, mb_rd_sel, local_irq_n, mb_rd, mb_load,
                   local_wr_n_in, local_rd_n_in, local_clock};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign lclk_rise = sync2[0] && !sync3[0];
   assign rd_rise = sync2[1] && !sync3[1];
   assign rd_low = !sync2[1];
   assign wr_rise = sync2[2] && !sync3[2];
   assign load_rise = sync2[3] && !sync3[3];
   assign mbrd_rise = sync2[4] && !sync3[4];

   // Control register and window settings; a start-up load overrides
   // a register write to the same window in the same cycle.
   always_ff @(posedge clock)
   begin
      if (reset)
         ctrl <= `PTB_CTRL_RST;
      else if (reg_write && reg_addr == `PTB_A_CTRL)
         ctrl <= reg_wdata[`PTB_CTRL_W-1:0];
   end

   generate
      for (genvar w = 0; w < `PTB_WINDOWS; w++)
      begin : g_win
         always_ff @(posedge clock)
         begin
            if (reset)
               win_cfg[w] <= `PTB_WIN_RST;
            else if (cfg_load && cfg_load_window == 2'(w))
               win_cfg[w] <= cfg_load_value;
            else if (reg_write && reg_addr == `PTB_A_WIN0 + 8'(4 * w))
               win_cfg[w] <= reg_wdata[`PTB_WIN_W-1:0];
         end
      end
   endgenerate

   // Mailbox data: outbound written by PCI software, inbound by local pins.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         mb_out <= '0;
         mb_in <= '0;
      end
      else
      begin
         if (reg_write && reg_addr == `PTB_A_MB_OUT)
            mb_out <= reg_wdata;
         if (load_rise)
            mb_in <= sync2[39:8];
      end
   end

   // Byte full flags; a write in the same cycle as a read wins.
   generate
      for (genvar b = 0; b < 4; b++)
      begin : g_flag
         always_ff @(posedge clock)
         begin
            if (reset)
            begin
               out_full[b] <= 1'b0;
               in_full[b] <= 1'b0;
            end
            else
            begin
               if (reg_write && reg_addr == `PTB_A_MB_OUT)
                  out_full[b] <= 1'b1;
               else if (mbrd_rise && sync2[7:6] == 2'(b))
                  out_full[b] <= 1'b0;
               if (load_rise)
                  in_full[b] <= 1'b1;
               else if (reg_read && reg_addr == `PTB_A_MB_IN)
                  in_full[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // Interrupt pins and local mailbox outputs. The interrupt is a level
   // that stays until the selected byte is read, so nothing is missed.
   assign int_sel = ctrl[`PTB_C_SEL_HI:`PTB_C_SEL_LO];
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pci_int_n <= 1'b1;
         local_int_n <= 1'b1;
         mb_rd_data <= '0;
         mb_status <= '0;
      end
      else
      begin
         pci_int_n <= !((ctrl[`PTB_C_IEN_PCI] && in_full[int_sel]) || !sync2[5]);
         local_int_n <= !(ctrl[`PTB_C_IEN_LOC] && out_full[int_sel]);
         mb_rd_data <= mb_out[8 * sync2[7:6] +: 8];
         mb_status <= {in_full, out_full};
      end
   end

   // Register read data stands only in the cycle after the read strobe.
   always_ff @(posedge clock)
   begin
      if (reset || !reg_read)
         reg_rdata <= '0;
      else if (reg_addr >= `PTB_A_WIN0 && reg_addr <= `PTB_A_WIN3)
         reg_rdata <= 32'(win_cfg[reg_addr[3:2]]);
      else
         case (reg_addr)
            `PTB_A_MB_OUT: reg_rdata <= mb_out;
            `PTB_A_MB_IN: reg_rdata <= mb_in;
            `PTB_A_MB_STAT: reg_rdata <= {24'h0, in_full, out_full};
            `PTB_A_CTRL: reg_rdata <= 32'(ctrl);
            `PTB_A_FSTAT: reg_rdata <= {16'h0, 4'(rf_count), 4'(wf_count), 6'h0, pf_active, lreq_valid};
            default: reg_rdata <= '0;
         endcase
   end

   // Request entry: data, lanes, window, burst and in-window offset.
   assign req_cfg = win_cfg[win_req_window];
   assign req_entry = {win_req_wdata, win_req_be, win_req_window, win_req_burst,
                       win_req_addr & win_mask(req_cfg[`PTB_W_SZ_HI:`PTB_W_SZ_LO])};

   // Buffered traffic: writes enter without a wait while space remains,
   // reads leave from prefetched data; a write flushes stale prefetch.
   assign wf_push = win_req && win_req_write && ctrl[`PTB_C_WFEN] && !wf_full;
   assign rf_pop = win_req && !win_req_write && ctrl[`PTB_C_RFEN] && !rf_empty;
   assign rf_push = eng_done && eng_op == PTB_OP_PF_RD && pf_active;
   assign pf_flush = win_req && win_req_write;

   ptb_fifo #(.WIDTH(`PTB_WF_W)) u_wr_fifo
   (
      .clock(clock),
      .reset(reset),
      .flush(1'b0),
      .push(wf_push),
      .push_data(req_entry),
      .full(wf_full),
      .pop(eng_go && pick == PTB_OP_FIFO_WR),
      .pop_data(wf_dout),
      .empty(wf_empty),
      .count(wf_count)
   );

   ptb_fifo #(.WIDTH(32)) u_rd_fifo
   (
      .clock(clock),
      .reset(reset),
      .flush(pf_flush),
      .push(rf_push),
      .push_data(eng_rdata),
      .full(rf_full),
      .pop(rf_pop),
      .pop_data(rf_dout),
      .empty(rf_empty),
      .count(rf_count)
   );

   // Transaction tracking and the answer to the PCI core.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         win_ack <= 1'b0;
         win_retry <= 1'b0;
         win_rdata <= '0;
         dw_st <= PTB_T_NONE;
         rd_st <= PTB_T_NONE;
         dw_entry <= '0;
         rd_entry <= '0;
         rd_hold <= '0;
         pf_active <= 1'b0;
         pf_addr <= '0;
         pf_be <= '0;
         pf_win <= '0;
      end
      else
      begin
         win_ack <= 1'b0;
         win_retry <= 1'b0;
         if (eng_go && pick == PTB_OP_DIR_WR)
            dw_st <= PTB_T_ISSUED;
         if (eng_go && pick == PTB_OP_DIR_RD)
            rd_st <= PTB_T_ISSUED;
         if (eng_done && eng_op == PTB_OP_DIR_WR)
            dw_st <= PTB_T_DONE;
         if (eng_done && eng_op == PTB_OP_DIR_RD)
         begin
            rd_st <= PTB_T_DONE;
            rd_hold <= eng_rdata;
         end
         if (rf_push)
            pf_addr <= pf_addr + 29'h4;
         if (rf_full)
            pf_active <= 1'b0;
         if (win_req && win_req_write)
         begin
            pf_active <= 1'b0;
            if (ctrl[`PTB_C_WFEN])
            begin
               win_ack <= !wf_full;
               win_retry <= wf_full;
            end
            else if (dw_st == PTB_T_DONE)
            begin
               win_ack <= 1'b1;
               dw_st <= PTB_T_NONE;
            end
            else
            begin
               win_retry <= 1'b1;
               if (dw_st == PTB_T_NONE)
               begin
                  dw_st <= PTB_T_PEND;
                  dw_entry <= req_entry;
               end
            end
         end
         else if (win_req)
         begin
            if (ctrl[`PTB_C_RFEN] && !rf_empty)
            begin
               win_ack <= 1'b1;
               win_rdata <= rf_dout;
            end
            else if (ctrl[`PTB_C_RFEN])
            begin
               win_retry <= 1'b1;
               if (!pf_active)
               begin
                  pf_active <= 1'b1;
                  pf_addr <= req_entry[28:0];
                  pf_be <= win_req_be;
                  pf_win <= win_req_window;
               end
            end
            else if (rd_st == PTB_T_DONE)
            begin
               win_ack <= 1'b1;
               win_rdata <= rd_hold;
               rd_st <= PTB_T_NONE;
            end
            else
            begin
               win_retry <= 1'b1;
               if (rd_st == PTB_T_NONE)
               begin
                  rd_st <= PTB_T_PEND;
                  rd_entry <= req_entry;
               end
            end
         end
      end
   end

   // Engine work selection: buffered writes first so reads see them.
   always_comb
   begin
      pick = PTB_OP_PF_RD;
      pick_entry = {32'h0, pf_be, pf_win, 1'b1, pf_addr};
      if (!wf_empty)
      begin
         pick = PTB_OP_FIFO_WR;
         pick_entry = wf_dout;
      end
      else if (dw_st == PTB_T_PEND)
      begin
         pick = PTB_OP_DIR_WR;
         pick_entry = dw_entry;
      end
      else if (rd_st == PTB_T_PEND)
      begin
         pick = PTB_OP_DIR_RD;
         pick_entry = rd_entry;
      end
   end

   assign eng_go = engine_state == PTB_E_IDLE && !eng_done
                   && (!wf_empty || dw_st == PTB_T_PEND || rd_st == PTB_T_PEND
                       || (pf_active && !rf_full && !pf_flush));

   // Local bus engine. Active mode holds its strobe for one plus the wait
   // count local clocks, then parks it high one clock before release.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         engine_state <= PTB_E_IDLE;
         eng_op <= PTB_OP_FIFO_WR;
         eng_done <= 1'b0;
         eng_rdata <= '0;
         wait_cnt <= '0;
         lreq_valid <= 1'b0;
         lreq_write <= 1'b0;
         lreq_be <= '0;
         lreq_window <= '0;
         lreq_burst <= 1'b0;
         lreq_addr <= '0;
         local_data_out <= '0;
         local_rd_n_out <= 1'b1;
         local_wr_n_out <= 1'b1;
         local_strobe_oe <= 1'b0;
      end
      else
      begin
         eng_done <= 1'b0;
         case (engine_state)
            PTB_E_IDLE:
            begin
               if (eng_go)
               begin
                  eng_op <= pick;
                  lreq_valid <= 1'b1;
                  lreq_write <= pick == PTB_OP_FIFO_WR || pick == PTB_OP_DIR_WR;
                  {local_data_out, lreq_be, lreq_window, lreq_burst, lreq_addr} <= pick_entry;
                  wait_cnt <= ctrl[`PTB_C_WS_HI:`PTB_C_WS_LO];
                  if (ctrl[`PTB_C_ACT])
                  begin
                     engine_state <= PTB_E_STROBE;
                     local_strobe_oe <= 1'b1;
                     local_rd_n_out <= pick[1] == 1'b0;
                     local_wr_n_out <= pick[1] == 1'b1;
                  end
                  else
                     engine_state <= PTB_E_PASV;
               end
            end
            PTB_E_STROBE:
            begin
               if (lclk_rise && wait_cnt != 3'h0)
                  wait_cnt <= wait_cnt - 3'h1;
               else if (lclk_rise)
               begin
                  eng_rdata <= sync2[71:40];
                  local_rd_n_out <= 1'b1;
                  local_wr_n_out <= 1'b1;
                  lreq_valid <= 1'b0;
                  engine_state <= PTB_E_PARK;
               end
            end
            PTB_E_PARK:
            begin
               if (lclk_rise)
               begin
                  local_strobe_oe <= 1'b0;
                  eng_done <= 1'b1;
                  engine_state <= PTB_E_IDLE;
               end
            end
            PTB_E_PASV:
            begin
               if ((lreq_write && rd_rise) || (!lreq_write && wr_rise))
               begin
                  eng_rdata <= sync2[71:40];
                  lreq_valid <= 1'b0;
                  eng_done <= 1'b1;
                  engine_state <= PTB_E_IDLE;
               end
            end
            default: engine_state <= PTB_E_IDLE;
         endcase
      end
   end

   // Data drive: active writes hold data through the strobe; in passive
   // mode data is driven while the user holds its read strobe low.
   assign local_data_oe = lreq_valid && lreq_write
                          && (engine_state == PTB_E_STROBE || (engine_state == PTB_E_PASV && rd_low));
   assign lreq_width = win_cfg[lreq_window][`PTB_W_WID_HI:0];
   assign lreq_io = win_cfg[lreq_window][`PTB_W_IO];
endmodule

// *** ptb_bridge_assertions.sv ***
/*
 Port checker for ptb_bridge.
 Assumes it is bound to every ptb_bridge instance.
*/
`timescale 1ns/1ns
`include "ptb_consts.svh"
module ptb_bridge_assertions
(
   // Watched ports
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic win_req,
   input wire logic win_ack,
   input wire logic win_retry,
   input wire logic local_strobe_oe,
   input wire logic local_rd_n_out,
   input wire logic local_wr_n_out,
   input wire logic lreq_valid,
   input wire logic lreq_write,
   input wire logic [7:0] mb_status,
   input wire logic local_irq_n,
   input wire logic pci_int_n
);
   // One domain, so clock and reset are given once.
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   answer_once_a: assert property (win_req |=> win_ack ^ win_retry)
      else $error("window request not answered once");
   answer_cause_a: assert property ((win_ack || win_retry) |-> $past(win_req))
      else $error("window answer without request");
   park_high_a: assert property ($fell(local_strobe_oe) |-> $past(local_rd_n_out && local_wr_n_out))
      else $error("strobe floated while low");
   irq_pass_a: assert property ($fell(local_irq_n) |-> ##[1:4] !pci_int_n)
      else $error("local interrupt pin not passed on");
   wr_strobe_a: assert property (!local_wr_n_out |-> lreq_valid && lreq_write)
      else $error("write strobe without write request");
   rd_strobe_a: assert property (!local_rd_n_out |-> lreq_valid && !lreq_write)
      else $error("read strobe without read request");
   out_full_a: assert property (reg_write && reg_addr == `PTB_A_MB_OUT |-> ##[1:2] mb_status[3:0] == 4'hf)
      else $error("outbound flags not set");
   in_clear_a: assert property (reg_read && reg_addr == `PTB_A_MB_IN |-> ##[1:2] mb_status[7:4] == 4'h0)
      else $error("inbound flags not cleared");
   // Main scenarios.
   retry_c: cover property (win_req ##1 win_retry);
   wr_c: cover property (!local_wr_n_out);
   rd_c: cover property (!local_rd_n_out);
endmodule
bind ptb_bridge ptb_bridge_assertions u_ptb_bridge_assertions (.*);

// *** ptb_consts.svh ***
/*
 Named constants of the local bus bridge: register byte offsets,
 field positions, reset values and buffer sizes.
 Assumes it is included by bare name from the bridge, checker, FIFO and bench modules.
*/
`ifndef PTB_CONSTS_SVH
`define PTB_CONSTS_SVH

// Register byte offsets on the register port.
`define PTB_A_MB_OUT 8'h00
`define PTB_A_MB_IN 8'h04
`define PTB_A_MB_STAT 8'h08
`define PTB_A_CTRL 8'h0c
`define PTB_A_WIN0 8'h10
`define PTB_A_WIN3 8'h1c
`define PTB_A_FSTAT 8'h20

// Control register fields and reset value.
`define PTB_C_WFEN 0
`define PTB_C_RFEN 1
`define PTB_C_ACT 2
`define PTB_C_WS_LO 3
`define PTB_C_WS_HI 5
`define PTB_C_SEL_LO 6
`define PTB_C_SEL_HI 7
`define PTB_C_IEN_PCI 8
`define PTB_C_IEN_LOC 9
`define PTB_CTRL_W 10
`define PTB_CTRL_RST 10'h000

// Window configuration fields: width code, I/O space, log2 of size, enable.
`define PTB_W_WID_HI 1
`define PTB_W_IO 2
`define PTB_W_SZ_LO 3
`define PTB_W_SZ_HI 7
`define PTB_W_EN 8
`define PTB_WIN_W 9
`define PTB_WIN_RST 9'h162
`define PTB_WINDOWS 4

// Buffers: 8 dwords hold 32 bytes.
`define PTB_FIFO_DEPTH 8
`define PTB_FIFO_AW 3
`define PTB_WF_W 68
`define PTB_SYNC_W 72
`define PTB_SYNC_RST 72'h26
`define PTB_ADDR_ALL 29'h1fffffff

`endif

// *** ptb_fifo.sv ***
/*
 Synchronous FIFO of eight entries for the window data paths.
 Assumes one clock; pushes when full and pops when empty are not made.
*/
`timescale 1ns/1ns
`include "ptb_consts.svh"
module ptb_fifo
#(
   parameter int WIDTH = 32
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Filling side
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   output logic full,
   // Draining side
   input wire logic pop,
   output logic [WIDTH-1:0] pop_data,
   output logic empty,
   output logic [`PTB_FIFO_AW:0] count
);
   logic [WIDTH-1:0] mem [`PTB_FIFO_DEPTH];
   logic [`PTB_FIFO_AW-1:0] wr_ptr;
   logic [`PTB_FIFO_AW-1:0] rd_ptr;

   // Storage is written only on an accepted push.
   always_ff @(posedge clock)
   begin
      if (push && !full)
         mem[wr_ptr] <= push_data;
   end

   // Pointers and fill level; flush drops all contents at once.
   always_ff @(posedge clock)
   begin
      if (reset || flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push && !full)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop && !empty)
            rd_ptr <= rd_ptr + 1'b1;
         count <= count + {3'h0, push && !full} - {3'h0, pop && !empty};
      end
   end

   assign full = (count == (`PTB_FIFO_AW+1)'(`PTB_FIFO_DEPTH));
   assign empty = (count == '0);
   assign pop_data = mem[rd_ptr];
endmodule

// *** ptb_local_model.sv ***
/*
 Local bus logic model: eight dwords of storage served in active mode.
 Assumes the bridge engine drives the strobes, data and lreq_addr.
*/
`timescale 1ns/1ns
module ptb_local_model
(
   // Free-running bus clock
   output logic local_clock,
   // Engine side, watched; read data driven back
   input wire logic local_rd_n_out,
   input wire logic local_wr_n_out,
   input wire logic local_data_oe,
   input wire logic [31:0] local_data_out,
   input wire logic [28:0] lreq_addr,
   output logic [31:0] local_data_in
);
   logic [31:0] mem [0:7];
   // The bus clock runs free at 160 ns, offset from the core clock.
   initial
   begin
      local_clock = 1'b0;
      #7;
      forever #80 local_clock = ~local_clock;
   end
   // A write lands at a bus edge while the engine drives data.
   always @(posedge local_clock)
   begin
      if (!local_wr_n_out && local_data_oe)
         mem[lreq_addr[4:2]] <= local_data_out;
   end
   // Undriven data toggles, so stale values cannot pass for read data.
   assign local_data_in = !local_rd_n_out ? mem[lreq_addr[4:2]] : 32'h5a5a5a5a ^ {32{local_clock}};
endmodule

// *** ptb_pkg.sv ***
/*
 Types shared by the local bus bridge modules.
 Assumes ptb_consts.svh is on the include path.
*/
package ptb_pkg;
   // Local bus engine states.
   typedef enum logic [2:0]
   {
      PTB_E_IDLE = 3'h0,
      PTB_E_STROBE = 3'h1,
      PTB_E_PARK = 3'h2,
      PTB_E_PASV = 3'h3
   } ptb_eng_t;

   // Source of the transfer the engine works on.
   typedef enum logic [1:0]
   {
      PTB_OP_FIFO_WR = 2'h0,
      PTB_OP_DIR_WR = 2'h1,
      PTB_OP_DIR_RD = 2'h2,
      PTB_OP_PF_RD = 2'h3
   } ptb_op_t;

   // Progress of a direct (unbuffered) window transfer.
   typedef enum logic [1:0]
   {
      PTB_T_NONE = 2'h0,
      PTB_T_PEND = 2'h1,
      PTB_T_ISSUED = 2'h2,
      PTB_T_DONE = 2'h3
   } ptb_tr_t;
endpackage

// *** tb_ptb_bridge.sv ***
/*
 Self-checking bench for ptb_bridge: registers, mailboxes, windows.
 Assumes ptb_local_model stands on the local bus.
*/
`timescale 1ns/1ns
`include "ptb_consts.svh"
module tb_ptb_bridge;
   import ptb_pkg::*;
   logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, win_req = 1'b0, win_req_write = 1'b0;
   logic mb_load = 1'b0, mb_rd = 1'b0, local_irq_n = 1'b1, win_ack, win_retry, pci_int_n, local_int_n;
   logic local_rd_n_out, local_wr_n_out, local_strobe_oe, local_data_oe, local_clock, lreq_valid, lreq_write;
   logic [7:0] reg_addr = 8'h00;
   logic [1:0] mb_rd_sel = 2'h0;
   logic [31:0] reg_wdata = 32'h0, win_req_wdata = 32'h0, mb_load_data = 32'h0, q;
   logic [31:0] reg_rdata, win_rdata, local_data_in, local_data_out;
   logic [28:0] lreq_addr, win_req_addr = 29'h40;
   logic cfg_load = 1'b0;
   logic [1:0] cfg_load_window = 2'h2;
   logic [8:0] cfg_load_value = 9'h1a5;
   logic [7:0] mb_rd_data, mb_status;
   int fails = 0, checks_done = 0, cycles = 0, tries;
   ptb_bridge u_ptb_bridge (.*, .win_req_window(2'h1), .win_req_be(4'hf), .win_req_burst(1'b0),
      .local_rd_n_in(1'b1), .local_wr_n_in(1'b1), .lreq_be(), .lreq_window(), .lreq_burst(), .lreq_width(),
      .lreq_io(), .engine_state());
   ptb_local_model u_ptb_local_model (.*);
   // Core clock, 20 ns period.
   initial
   begin
      forever #10 clock = ~clock;
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task results();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task rd(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      check(n, reg_rdata, e);
   endtask
   // Re-presents the request after each retry, with a bound.
   task win(input logic w, input logic [31:0] d);
      tries = 0;
      do
      begin
         @(posedge clock);
         win_req <= 1'b1;
         win_req_write <= w;
         win_req_wdata <= d;
         @(posedge clock);
         win_req <= 1'b0;
         #1;
         tries++;
      end
      while (win_ack !== 1'b1 && tries < 400);
      q = win_rdata;
      check("window ack", {31'h0, win_ack}, 32'h1);
   endtask
   task pins(input logic rd_pin, input logic ld_pin);
      @(posedge clock);
      mb_rd <= rd_pin;
      mb_load <= ld_pin;
      repeat (5) @(posedge clock);
      #1;
   endtask
   // A hang counts as a mismatch.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         results();
      end
   end
   initial
   begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      rd("ctrl", `PTB_A_CTRL, 32'h0);
      rd("window 3", `PTB_A_WIN3, 32'h162);
      rd("unmapped", 8'hfc, 32'h0);
      cfg_load <= 1'b1;
      @(posedge clock);
      cfg_load <= 1'b0;
      rd("loaded", `PTB_A_WIN0 + 8'h8, 32'h1a5);
      $display("test defaults done");
      wr(`PTB_A_MB_OUT, 32'h11223344);
      rd("status", `PTB_A_MB_STAT, 32'h0f);
      rd("outbound", `PTB_A_MB_OUT, 32'h11223344);
      mb_rd_sel <= 2'h2;
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      check("byte 2", {24'h0, mb_rd_data}, 32'h22);
      check("out flags", {24'h0, mb_status}, 32'h0b);
      wr(`PTB_A_CTRL, 32'h200);
      repeat (3) @(posedge clock);
      check("local int", {31'h0, local_int_n}, 32'h0);
      wr(`PTB_A_CTRL, 32'h280);
      repeat (3) @(posedge clock);
      check("local int sel", {31'h0, local_int_n}, 32'h1);
      wr(`PTB_A_CTRL, 32'h100);
      mb_load_data <= 32'hcafe0001;
      pins(1'b0, 1'b1);
      pins(1'b0, 1'b0);
      check("pci int", {31'h0, pci_int_n}, 32'h0);
      check("in flags", {24'h0, mb_status}, 32'hfb);
      rd("inbound", `PTB_A_MB_IN, 32'hcafe0001);
      repeat (3) @(posedge clock);
      check("pci int off", {31'h0, pci_int_n}, 32'h1);
      local_irq_n <= 1'b0;
      repeat (5) @(posedge clock);
      check("irq pin", {31'h0, pci_int_n}, 32'h0);
      local_irq_n <= 1'b1;
      $display("test mailbox done");
      wr(`PTB_A_CTRL, 32'h1d);
      win(1'b1, 32'h600dbeef);
      check("fifo write tries", tries, 32'h1);
      wr(`PTB_A_CTRL, 32'h1c);
      win(1'b0, 32'h0);
      check("read data", q, 32'h600dbeef);
      check("read retried", {31'h0, tries > 1}, 32'h1);
      check("local word", u_ptb_local_model.mem[0], 32'h600dbeef);
      win_req_addr <= 29'h1040;
      win(1'b1, 32'h0badf00d);
      check("write retried", {31'h0, tries > 1}, 32'h1);
      check("direct word", u_ptb_local_model.mem[0], 32'h0badf00d);
      wr(`PTB_A_CTRL, 32'h1e);
      win(1'b0, 32'h0);
      check("prefetch data", q, 32'h0badf00d);
      $display("test window done");
      results();
   end
endmodule
